// [hdl/rpw_pkg.sv]
// constants, types and states shared by the rgb pwm sink driver
package rpw_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CLK_FREQ_KHZ = 250000;
  localparam int unsigned REF_OSC_KHZ = 12000;
  localparam int unsigned REF_TICK_DIV = CLK_FREQ_KHZ / REF_OSC_KHZ;
  localparam int unsigned BIT_PERIOD_MIN_NS = 330;
  localparam int unsigned BIT_PERIOD_MAX_NS = 10000;
  localparam int unsigned BIT_PERIOD_MIN_CYC =
    (BIT_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BIT_PERIOD_MAX_CYC = BIT_PERIOD_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned FWD_PULSE_NS = 25;
  localparam int unsigned FWD_PULSE_CYC = (FWD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PACKET_END_HOLD_PERIODS = 4;
  localparam int unsigned LATCH_HOLD_PERIODS = 8;
  localparam int unsigned ONE_LIMIT_DIV = 2;
  localparam int unsigned ZERO_LIMIT_NUM = 9;
  localparam int unsigned ZERO_LIMIT_DEN = 10;

  localparam int unsigned NUM_CH = 3;
  localparam int unsigned BRIGHT_W = 12;
  localparam int unsigned SHIFT_W = 48;
  localparam int unsigned TIME_W = 16;
  localparam int unsigned DIV_W = 5;
  localparam int unsigned PULSE_W = 4;

  localparam logic [11:0] WRITE_KEY = 12'h3aa;
  localparam logic [11:0] BRIGHT_RST = 12'h000;
  localparam logic [11:0] PWM_CNT_RST = 12'h000;
  localparam logic [47:0] SHIFT_RST = 48'h0;
  localparam logic [15:0] TIME_RST = 16'h0;
  localparam logic [15:0] TIME_START = 16'h1;
  localparam logic [4:0] DIV_RST = 5'h0;
  localparam logic [3:0] PULSE_RST = 4'h0;

  // channel 0 sits just below the key, channel 2 at the lsb end
  typedef struct packed {
    logic [0:2][11:0] ch;
  } rpw_bright_s;

  typedef struct packed {
    logic [11:0] key;
    rpw_bright_s bright;
  } rpw_packet_s;

  typedef enum logic [2:0] {
    ST_MEAS_FIRST = 3'b000,
    ST_MEAS_SECOND = 3'b001,
    ST_GAP = 3'b010,
    ST_CELL = 3'b011,
    ST_CELL_TAIL = 3'b100,
    ST_FORWARD = 3'b101
  } rpw_state_e;
endpackage

// [hdl/rpw_top.sv]
// rgb pwm sink driver: single-wire decoder, packet forwarder and 3-channel 12-bit pwm
`timescale 1ns/10ps
module rpw_top (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic serial_in_line_i,
  output logic [rpw_pkg::NUM_CH-1:0] sink_output_o,
  output logic serial_out_line_o,
  output logic packet_locked_o
);
  import rpw_pkg::*;

  logic in_meta_q;
  logic in_sync_q;
  logic in_prev_q;
  logic rise;
  logic [DIV_W-1:0] div_q;
  logic brightness_ref_tick_q;
  rpw_state_e state_q;
  logic [TIME_W-1:0] tm_q;
  logic [TIME_W-1:0] low_q;
  logic [TIME_W-1:0] bit_period_q;
  logic [TIME_W-1:0] one_limit_q;
  logic [TIME_W-1:0] zero_limit_q;
  logic [TIME_W-1:0] packet_end_hold_q;
  logic [TIME_W-1:0] latch_hold_q;
  rpw_packet_s shreg_q;
  rpw_bright_s bright_q;
  logic [BRIGHT_W-1:0] pwm_cnt_q;
  logic [PULSE_W-1:0] pulse_q;
  logic [NUM_CH-1:0] sink_q;
  logic serial_out_q;
  logic locked_q;
  logic latch_fire;
  logic load;

  // two flops for the line, a third only as the edge history
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      in_meta_q <= 1'b0;
      in_sync_q <= 1'b0;
      in_prev_q <= 1'b0;
    end else begin
      in_meta_q <= serial_in_line_i;
      in_sync_q <= in_meta_q;
      in_prev_q <= in_sync_q;
    end
  end

  assign rise = in_sync_q & ~in_prev_q;

  // internal brightness reference, no external clock needed
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || load) begin
      div_q <= DIV_RST;
      brightness_ref_tick_q <= 1'b0;
    end else if (div_q == DIV_W'(REF_TICK_DIV - 1)) begin
      div_q <= DIV_RST;
      brightness_ref_tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      brightness_ref_tick_q <= 1'b0;
    end
  end

  // time since the current cell or measurement started, saturating
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tm_q <= TIME_RST;
    end else if (rise && (state_q != ST_CELL) && (state_q != ST_CELL_TAIL)) begin
      // start at one so the count at the next edge equals the elapsed cycles
      tm_q <= TIME_START;
    end else if (tm_q != {TIME_W{1'b1}}) begin
      tm_q <= tm_q + 1'b1;
    end
  end

  // low-hold length, cleared whenever the line is high
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || in_sync_q) begin
      low_q <= TIME_RST;
    end else if (low_q != {TIME_W{1'b1}}) begin
      low_q <= low_q + 1'b1;
    end
  end

  // latch hold can only be reached once a period exists
  assign latch_fire = (state_q != ST_MEAS_FIRST) && (state_q != ST_MEAS_SECOND) &&
                      (low_q >= latch_hold_q);
  assign load = latch_fire && (shreg_q.key == WRITE_KEY);

  // serial decoder
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= ST_MEAS_FIRST;
      shreg_q <= SHIFT_RST;
      bit_period_q <= TIME_RST;
      one_limit_q <= TIME_RST;
      zero_limit_q <= TIME_RST;
      packet_end_hold_q <= TIME_RST;
      latch_hold_q <= TIME_RST;
    end else if (latch_fire) begin
      state_q <= ST_MEAS_FIRST;
    end else begin
      case (state_q)
        ST_MEAS_FIRST: begin
          if (rise) begin
            state_q <= ST_MEAS_SECOND;
          end
        end
        ST_MEAS_SECOND: begin
          if (rise && (tm_q >= TIME_W'(BIT_PERIOD_MIN_CYC))) begin
            // out-of-range periods restart measurement from this edge
            if (tm_q <= TIME_W'(BIT_PERIOD_MAX_CYC)) begin
              bit_period_q <= tm_q;
              one_limit_q <= TIME_W'(tm_q / ONE_LIMIT_DIV);
              zero_limit_q <= TIME_W'((tm_q * ZERO_LIMIT_NUM) / ZERO_LIMIT_DEN);
              packet_end_hold_q <= TIME_W'(tm_q * PACKET_END_HOLD_PERIODS);
              latch_hold_q <= TIME_W'(tm_q * LATCH_HOLD_PERIODS);
              shreg_q <= {shreg_q[SHIFT_W-3:0], 2'b00};
              state_q <= ST_GAP;
            end
          end else if (tm_q > TIME_W'(BIT_PERIOD_MAX_CYC)) begin
            state_q <= ST_MEAS_FIRST;
          end
        end
        ST_GAP: begin
          if (rise) begin
            state_q <= ST_CELL;
          end else if (low_q >= packet_end_hold_q) begin
            state_q <= ST_FORWARD;
          end
        end
        ST_CELL: begin
          if (rise && (tm_q < one_limit_q)) begin
            shreg_q <= {shreg_q[SHIFT_W-2:0], 1'b1};
            state_q <= ST_CELL_TAIL;
          end else if (tm_q >= zero_limit_q) begin
            shreg_q <= {shreg_q[SHIFT_W-2:0], 1'b0};
            state_q <= ST_GAP;
          end
        end
        ST_CELL_TAIL: begin
          // edges between the one and zero limits are ambiguous and ignored
          if (tm_q >= zero_limit_q) begin
            state_q <= ST_GAP;
          end
        end
        ST_FORWARD: begin
          state_q <= ST_FORWARD;
        end
        default: begin
          state_q <= ST_MEAS_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= (state_q == ST_FORWARD) && !latch_fire;
    end
  end

  // regenerated fixed-width pulse per rising edge keeps edge timing intact downstream
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pulse_q <= PULSE_RST;
      serial_out_q <= 1'b0;
    end else if ((state_q == ST_FORWARD) && rise) begin
      pulse_q <= PULSE_W'(FWD_PULSE_CYC - 1);
      serial_out_q <= 1'b1;
    end else if (pulse_q != PULSE_RST) begin
      pulse_q <= pulse_q - 1'b1;
      serial_out_q <= 1'b1;
    end else begin
      serial_out_q <= 1'b0;
    end
  end

  // brightness latch starts at zero so outputs stay dark until loaded
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      bright_q <= {NUM_CH{BRIGHT_RST}};
    end else if (load) begin
      bright_q <= shreg_q.bright;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || load) begin
      pwm_cnt_q <= PWM_CNT_RST;
    end else if (brightness_ref_tick_q) begin
      pwm_cnt_q <= pwm_cnt_q + 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      always_ff @(posedge ref_clk_i) begin
        if (srst_i || load) begin
          sink_q[g] <= 1'b0;
        end else begin
          sink_q[g] <= (pwm_cnt_q != PWM_CNT_RST) &&
                       (pwm_cnt_q <= bright_q.ch[g]);
        end
      end
    end
  endgenerate

  assign sink_output_o = sink_q;
  assign serial_out_line_o = serial_out_q;
  assign packet_locked_o = locked_q;
endmodule

// [tb/rpw_checker.sv]
// port assertions for the rgb pwm sink driver
`timescale 1ns/10ps
module rpw_checker (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic serial_in_line_i,
  input wire logic [rpw_pkg::NUM_CH-1:0] sink_output_o,
  input wire logic serial_out_line_o,
  input wire logic packet_locked_o
);
  import rpw_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  a_rst_quiet: assert property (
    disable iff (1'b0) srst_i |=> !sink_output_o && !serial_out_line_o && !packet_locked_o)
    else $error("outputs not off after reset");
  a_fwd_locked: assert property (
    $rose(serial_out_line_o) |-> packet_locked_o)
    else $error("forward pulse while unlocked");
  a_pulse_width: assert property (
    $rose(serial_out_line_o) |=> serial_out_line_o [*6] ##1 !serial_out_line_o)
    else $error("forward pulse width wrong");
  a_pulse_cause: assert property (
    $rose(serial_out_line_o) |-> $past(serial_in_line_i, 2))
    else $error("forward pulse without input rise");
  a_out_idle: assert property (
    !packet_locked_o && !$past(packet_locked_o, 8) |-> !serial_out_line_o)
    else $error("serial out active while not forwarding");
  // a lock needs a long low: 300 cycles is below the shortest end hold
  a_lock_idle: assert property (
    $rose(packet_locked_o) |-> !$past(serial_in_line_i) && !$past(serial_in_line_i, 300))
    else $error("lock without low hold");
  a_on_min: assert property (
    $fell(sink_output_o[0]) |-> $past(sink_output_o[0], 19))
    else $error("on time below one tick");
  a_sink_steady: assert property (
    $changed(sink_output_o) |=> $stable(sink_output_o) [*8])
    else $error("sink changed between ticks");
endmodule
bind rpw_top rpw_checker u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
  .serial_in_line_i(serial_in_line_i), .sink_output_o(sink_output_o),
  .serial_out_line_o(serial_out_line_o), .packet_locked_o(packet_locked_o));

// [tb/rpw_host.sv]
// serial line host model that sends packets msb first
`timescale 1ns/10ps
module rpw_host (
  input wire logic ref_clk_i,
  output logic line_o
);
  import rpw_pkg::*;
  localparam int P = 100;
  initial line_o = 1'b0;
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic rise();
    line_o = 1'b1;
    wt(10);
    line_o = 1'b0;
  endtask
  // the first two cells time the bit period and stand for the key's two top zeros
  task automatic send(input logic [47:0] p);
    for (int i = 0; i < 48; i++) begin
      rise();
      if (i > 1 && p[47-i]) begin
        wt(15);
        rise();
        wt(65);
      end else begin
        wt(P - 10);
      end
    end
  endtask
endmodule

// [tb/rpw_top_test.sv]
// self-checking bench for the rgb pwm sink driver
`timescale 1ns/10ps
module rpw_top_test;
  import rpw_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic line;
  logic [NUM_CH-1:0] sink;
  logic so, so_q, locked;
  int n_errors = 0;
  int checked = 0;
  int fwd = 0;
  always #2 clk = ~clk;
  rpw_host u_host (.ref_clk_i(clk), .line_o(line));
  rpw_top u_dut (.ref_clk_i(clk), .srst_i(srst), .serial_in_line_i(line),
    .sink_output_o(sink), .serial_out_line_o(so), .packet_locked_o(locked));
  always @(posedge clk) begin
    so_q <= so;
    if (so === 1'b1 && so_q === 1'b0)
      fwd <= fwd + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one tick is 20 clocks, so on-time in clocks is value times 20
  task automatic meas(input int e0, input int e1, input int e2);
    int on[3] = '{0, 0, 0};
    repeat (400) begin
      u_host.wt(1);
      for (int k = 0; k < 3; k++) on[k] += sink[k];
    end
    chk(on[0], e0);
    chk(on[1], e1);
    chk(on[2], e2);
  endtask
  task automatic t_reset();
    chk(sink, 0);
    chk(locked, 0);
  endtask
  task automatic t_load();
    u_host.send({WRITE_KEY, 12'h003, 12'h000, 12'h001});
    u_host.wt(400);
    chk(locked, 1);
    chk(sink, 0);
    u_host.wt(300);
    meas(60, 0, 20);
  endtask
  task automatic t_badkey();
    u_host.send({12'h3ab, 12'hfff, 12'hfff, 12'hfff});
    u_host.wt(700);
    meas(0, 0, 0);
  endtask
  // second packet must pass through while the first stays frozen
  task automatic t_fwd();
    logic [47:0] b;
    int f0;
    b = {WRITE_KEY, 12'h0f0, 12'h000, 12'h001};
    u_host.send({WRITE_KEY, 12'h002, 12'h002, 12'h002});
    u_host.wt(400);
    f0 = fwd;
    u_host.send(b);
    chk(fwd - f0, 48 + $countones(b[45:0]));
    u_host.wt(700);
    meas(40, 40, 40);
  endtask
  // reset in mid-run must leave the sinks dark and unlocked, then a fresh packet must load
  task automatic t_midrst();
    srst = 1'b1;
    u_host.wt(3);
    srst = 1'b0;
    chk(sink, 0);
    chk(locked, 0);
    u_host.send({WRITE_KEY, 12'h001, 12'h001, 12'h001});
    u_host.wt(700);
    meas(20, 20, 20);
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    t_reset();
    t_load();
    t_badkey();
    t_fwd();
    t_midrst();
    summarize();
  end
  initial begin
    #300000;
    n_errors++;
    summarize();
  end
endmodule
